/* logic/psic_pkg.sv */
package psic_pkg;
   localparam int          PSIC_DW          = 32;
   localparam int          PSIC_AW          = 8;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0]  PSIC_IDX_CTRL    = 8'h11;
   localparam logic [7:0]  PSIC_IDX_ISTAT   = 8'h12;
   localparam logic [7:0]  PSIC_IDX_SUMM    = 8'h10;
   localparam logic [7:0]  PSIC_IDX_APBSTAT = 8'h18;
   localparam logic [7:0]  PSIC_IDX_APBMASK = 8'h19;
   localparam logic [15:0] PSIC_RST16       = 16'h0000;
   localparam int          PSIC_NEV         = 7;
   // Summary fields
   localparam int          PSIC_S_LINK      = 0;
   localparam int          PSIC_S_SPD10     = 1;
   localparam int          PSIC_S_DUP       = 2;
   localparam int          PSIC_S_LOOP      = 3;
   localparam int          PSIC_S_ANDONE    = 4;
   localparam int          PSIC_S_JAB       = 5;
   localparam int          PSIC_S_IRQ       = 7;
   // Control fields
   localparam int          PSIC_C_OE        = 0;
   localparam int          PSIC_C_GATE      = 1;
   localparam int          PSIC_C_TEST      = 2;
   localparam int          PSIC_C_W         = 3;
   // Event status sits at bit 8 upward, enables at bit 0 upward
   localparam int          PSIC_EV_STAT_LSB = 8;
   // Event order: 0 rx-err half, 1 false-carrier half, 2 an done, 3 duplex,
   // 4 speed, 5 link, 6 energy detect
   localparam int          PSIC_EV_RXH      = 0;
   localparam int          PSIC_EV_FCH      = 1;
   localparam int          PSIC_EV_ANC      = 2;
   localparam int          PSIC_EV_DUP      = 3;
   localparam int          PSIC_EV_SPD      = 4;
   localparam int          PSIC_EV_LINK     = 5;
   localparam int          PSIC_EV_ED       = 6;
   localparam int          PSIC_APB_NIRQ    = 2;
endpackage

/* logic/psic_sync_if.sv */
`timescale 1ns/1ns
interface psic_sync_if #(parameter int W = 8);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport top  (output raw, input synced);
   modport sync (input raw, output synced);
endinterface

/* logic/psic_sync.sv */
`timescale 1ns/1ns
module psic_sync
   import psic_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   psic_sync_if.sync sif
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] hold_r;
   logic [W-1:0] hold_nxt;

   always_comb begin
      meta_nxt = sif.raw;
      hold_nxt = meta_r;
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         meta_r <= '0;
         hold_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         hold_r <= hold_nxt;
      end
   end

   assign sif.synced = hold_r;
endmodule

/* logic/psic_top.sv */
// Summary of operation
// R1 - Summary bit 5 shows jabber; meaningful only at 10 Mb/s.
// R2 - Jabber mirrors basic status jabber; summary read never clears it.
// R3 - Summary bit 4 is one once auto-negotiation completes.
// R4 - Summary bit 3 is one while loopback is enabled.
// R5 - Summary bit 2 shows duplex, one is full, from negotiation or forcing.
// R6 - Summary bit 1 shows speed, one is 10 Mb/s, zero is 100.
// R7 - Software trusts speed and duplex only with link and settled negotiation.
// R8 - Summary bit 0 shows link; mirrors basic status, summary read keeps it.
// R9 - Control bits 15:3 ignore writes and read zero.
// R10 - Test bit forces interrupt while set; clearing stops it.
// R11 - Control bit 1 gates all event interrupts.
// R12 - Control bit 0 makes shared pin interrupt output, else power-down input.
// R13 - Sources: energy detect, link, speed, duplex, negotiation done, counters half.
// R14 - Event status bits set on event even when not enabled.
// R15 - Event status bits clear on the read that returns them.
// R16 - Summary bit 7 flags pending interrupt; status read clears it.
// R17 - Interrupt asserts on test bit or gated enabled pending event.
`timescale 1ns/1ns
module psic_top
   import psic_pkg::*;
(
   input  wire logic                  sys_clk_i,
   input  wire logic                  reset_i,
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [PSIC_AW+1:0]    paddr_i,
   input  wire logic [PSIC_DW-1:0]    pwdata_i,
   output logic      [PSIC_DW-1:0]    prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   input  wire logic                  link_up_i,
   input  wire logic                  speed10_i,
   input  wire logic                  full_duplex_i,
   input  wire logic                  loopback_i,
   input  wire logic                  an_done_i,
   input  wire logic                  jabber_i,
   input  wire logic                  energy_i,
   input  wire logic                  fc_half_i,
   input  wire logic                  rx_half_i,
   input  wire logic                  powerdown_or_irq_pin_i,
   output logic                       powerdown_or_irq_pin_o,
   output logic                       powerdown_or_irq_pin_oe_o,
   output logic                       powerdown_o,
   output logic                       irq_o
);
   localparam int SW = 10;

   psic_sync_if #(.W(SW)) sif ();
   psic_sync #(.W(SW)) u_sync (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .sif       (sif)
   );
   assign sif.raw = {powerdown_or_irq_pin_i, rx_half_i, fc_half_i, energy_i, jabber_i,
                     an_done_i, loopback_i, full_duplex_i, speed10_i, link_up_i};

   // Synchronised copies of the status pins, one flop pair each
   logic                     link_s;
   logic                     spd_s;
   logic                     dup_s;
   logic                     loop_s;
   logic                     anc_s;
   logic                     jab_s;
   logic                     ed_s;
   logic                     fch_s;
   logic                     rxh_s;
   logic                     pin_s;
   assign {pin_s, rxh_s, fch_s, ed_s, jab_s, anc_s, loop_s, dup_s, spd_s, link_s} = sif.synced;

   function automatic logic is_reg(input logic [PSIC_AW+1:0] a, input logic [7:0] idx);
      return (a[1:0] == 2'b00) && (a[PSIC_AW+1:2] == idx);
   endfunction

   logic [PSIC_NEV-1:0]      ev_lvl;
   logic [PSIC_NEV-1:0]      ev_hit;
   logic [PSIC_NEV-1:0]      prev_r;
   logic [PSIC_NEV-1:0]      prev_nxt;
   logic [PSIC_NEV-1:0]      pend_r;
   logic [PSIC_NEV-1:0]      pend_nxt;
   logic [PSIC_NEV-1:0]      en_r;
   logic [PSIC_NEV-1:0]      en_nxt;

   logic                     first_r;
   logic                     first_nxt;

   logic [PSIC_C_W-1:0]      ctrl_r;
   logic [PSIC_C_W-1:0]      ctrl_nxt;

   logic [PSIC_APB_NIRQ-1:0] ast_r;
   logic [PSIC_APB_NIRQ-1:0] ast_nxt;
   logic [PSIC_APB_NIRQ-1:0] ast_set;
   logic [PSIC_APB_NIRQ-1:0] amask_r;
   logic [PSIC_APB_NIRQ-1:0] amask_nxt;

   logic [PSIC_DW-1:0]       prdata_r;
   logic [PSIC_DW-1:0]       rd_nxt;
   logic                     ready_r;
   logic                     ready_nxt;
   logic                     err_r;
   logic                     err_nxt;

   logic                     int_r;
   logic                     int_nxt;
   logic                     irq_r;
   logic                     irq_nxt;
   logic                     pin_o_r;
   logic                     pin_o_nxt;
   logic                     pin_oe_r;
   logic                     pin_oe_nxt;
   logic                     pd_r;
   logic                     pd_nxt;

   logic                     wr_acc;
   logic                     rd_acc;
   logic                     rd_stat;
   logic [15:0]              summ;

   assign ev_lvl = {ed_s, link_s, spd_s, dup_s, anc_s, fch_s, rxh_s}; // see R13
   assign wr_acc = psel_i && penable_i && !ready_r && pwrite_i;
   assign rd_acc = psel_i && penable_i && !ready_r && !pwrite_i;
   assign rd_stat = rd_acc && is_reg(paddr_i, PSIC_IDX_ISTAT);

   // The event register packs enables and pending flags into one half-word
   if (PSIC_NEV > 7 || PSIC_C_W != 3) begin : g_size_chk
      $error("psic_top: event or control width out of range");
   end

   // Negotiation done and counter half-full fire on the rising edge only, so a
   // counter parked at half-full does not keep re-arming its pending bit
   for (genvar g = 0; g < PSIC_NEV; g++) begin : g_ev
      if (g == PSIC_EV_ANC || g == PSIC_EV_FCH || g == PSIC_EV_RXH) begin : g_rise
         assign ev_hit[g] = !first_r && ev_lvl[g] && !prev_r[g];
      end else begin : g_any
         assign ev_hit[g] = !first_r && (ev_lvl[g] != prev_r[g]);
      end
   end

   always_comb begin
      prev_nxt  = ev_lvl;
      first_nxt = 1'b0;
      pend_nxt  = pend_r;
      if (rd_stat) begin
         pend_nxt = '0; // see R15
      end
      // Set wins: an event landing in the clearing read stays pending
      pend_nxt = pend_nxt | ev_hit; // see R14
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         prev_r  <= '0;
         pend_r  <= '0;
         first_r <= 1'b1;
      end else begin
         prev_r  <= prev_nxt;
         pend_r  <= pend_nxt;
         first_r <= first_nxt;
      end
   end

   always_comb begin
      ctrl_nxt = ctrl_r;
      en_nxt   = en_r;
      if (wr_acc && is_reg(paddr_i, PSIC_IDX_CTRL)) begin
         // Only the live bits are stored, so reserved bits read back zero
         ctrl_nxt = pwdata_i[PSIC_C_W-1:0]; // see R9
      end
      if (wr_acc && is_reg(paddr_i, PSIC_IDX_ISTAT)) begin
         en_nxt = pwdata_i[PSIC_NEV-1:0];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         ctrl_r <= '0;
         en_r   <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         en_r   <= en_nxt;
      end
   end

   always_comb begin
      // see R10, R11, R17
      int_nxt    = ctrl_r[PSIC_C_TEST] | (ctrl_r[PSIC_C_GATE] & |(pend_r & en_r));
      pin_o_nxt  = int_nxt;
      pin_oe_nxt = ctrl_r[PSIC_C_OE]; // see R12
      // Power-down input is ignored while the pin is an output
      pd_nxt     = ~ctrl_r[PSIC_C_OE] & pin_s; // see R12
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         int_r    <= 1'b0;
         pin_o_r  <= 1'b0;
         pin_oe_r <= 1'b0;
         pd_r     <= 1'b0;
      end else begin
         int_r    <= int_nxt;
         pin_o_r  <= pin_o_nxt;
         pin_oe_r <= pin_oe_nxt;
         pd_r     <= pd_nxt;
      end
   end

   always_comb begin
      amask_nxt = amask_r;
      ast_nxt   = ast_r;
      if (wr_acc && is_reg(paddr_i, PSIC_IDX_APBMASK)) begin
         amask_nxt = pwdata_i[PSIC_APB_NIRQ-1:0];
      end
      if (wr_acc && is_reg(paddr_i, PSIC_IDX_APBSTAT)) begin
         ast_nxt = ast_r & ~pwdata_i[PSIC_APB_NIRQ-1:0];
      end
      // Wrapper status: bit 0 interrupt rose, bit 1 bad address; set beats clear
      ast_set = {err_nxt, int_nxt & ~int_r};
      ast_nxt = ast_nxt | ast_set;
      irq_nxt = |(ast_r & amask_r);
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         ast_r   <= '0;
         amask_r <= '0;
         irq_r   <= 1'b0;
      end else begin
         ast_r   <= ast_nxt;
         amask_r <= amask_nxt;
         irq_r   <= irq_nxt;
      end
   end

   always_comb begin
      summ = PSIC_RST16;
      summ[PSIC_S_LINK]   = link_s;   // see R8
      summ[PSIC_S_SPD10]  = spd_s;    // see R6
      summ[PSIC_S_DUP]    = dup_s;    // see R5
      summ[PSIC_S_LOOP]   = loop_s;   // see R4
      summ[PSIC_S_ANDONE] = anc_s;    // see R3
      summ[PSIC_S_JAB]    = jab_s;    // see R1, R2
      summ[PSIC_S_IRQ]    = int_r;    // see R16
      rd_nxt    = prdata_r;
      err_nxt   = 1'b0;
      // One wait state on every access keeps the answer a registered pulse
      ready_nxt = psel_i && penable_i && !ready_r;
      if (rd_acc) begin
         rd_nxt = '0;
      end
      if (psel_i && penable_i && !ready_r) begin
         if (paddr_i[1:0] != 2'b00) begin
            err_nxt = 1'b1;
         end else begin
            case (paddr_i[PSIC_AW+1:2])
               PSIC_IDX_SUMM: begin
                  if (!pwrite_i) begin
                     rd_nxt = {16'h0000, summ};
                  end
               end
               PSIC_IDX_CTRL: begin
                  if (!pwrite_i) begin
                     rd_nxt = {29'h00000000, ctrl_r};
                  end
               end
               PSIC_IDX_ISTAT: begin
                  if (!pwrite_i) begin
                     rd_nxt = {16'h0000, 1'b0, pend_r, 1'b0, en_r};
                  end
               end
               PSIC_IDX_APBSTAT: begin
                  if (!pwrite_i) begin
                     rd_nxt = {30'h00000000, ast_r};
                  end
               end
               PSIC_IDX_APBMASK: begin
                  if (!pwrite_i) begin
                     rd_nxt = {30'h00000000, amask_r};
                  end
               end
               default: begin
                  err_nxt = 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         prdata_r <= '0;
         ready_r  <= 1'b0;
         err_r    <= 1'b0;
      end else begin
         prdata_r <= rd_nxt;
         ready_r  <= ready_nxt;
         err_r    <= err_nxt;
      end
   end

   assign prdata_o                  = prdata_r;
   assign pready_o                  = ready_r;
   assign pslverr_o                 = err_r;
   assign powerdown_or_irq_pin_o    = pin_o_r;
   assign powerdown_or_irq_pin_oe_o = pin_oe_r;
   assign powerdown_o               = pd_r;
   assign irq_o                     = irq_r;
endmodule

/* tb/psic_monitor.sv */
`timescale 1ns/1ns
module psic_monitor
   import psic_pkg::*;
(
   input wire logic               sys_clk_i,
   input wire logic               reset_i,
   input wire logic               psel_i,
   input wire logic               penable_i,
   input wire logic               pwrite_i,
   input wire logic [PSIC_AW+1:0] paddr_i,
   input wire logic [PSIC_DW-1:0] pwdata_i,
   input wire logic               pready_o,
   input wire logic               pslverr_o,
   input wire logic               powerdown_or_irq_pin_o,
   input wire logic               powerdown_or_irq_pin_oe_o,
   input wire logic               powerdown_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   logic map_w;
   // Unaligned addresses are refused even when the index is mapped
   assign map_w = (paddr_i[1:0] == 2'b00) &&
                  (paddr_i[9:2] inside {PSIC_IDX_SUMM, PSIC_IDX_CTRL, PSIC_IDX_ISTAT,
                                        PSIC_IDX_APBSTAT, PSIC_IDX_APBMASK});
   sequence acc_s;
      psel_i && penable_i && pready_o;
   endsequence
   sequence ctl_wr_s;
      acc_s ##0 (pwrite_i && paddr_i[9:2] == PSIC_IDX_CTRL);
   endsequence
   ready_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("pready late");
   ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready long");
   err_unmap_a: assert property (acc_s ##0 !map_w |-> pslverr_o) else $error("no pslverr");
   err_map_a: assert property (acc_s ##0 map_w |-> !pslverr_o) else $error("bad pslverr");
   pin_role_a: assert property (powerdown_or_irq_pin_oe_o |-> !powerdown_o)
      else $error("pin role clash");
   oe_on_a: assert property (ctl_wr_s ##0 pwdata_i[0] |-> ##[1:2] powerdown_or_irq_pin_oe_o)
      else $error("pin not output");
   test_force_a: assert property (ctl_wr_s ##0 (pwdata_i[2] && pwdata_i[0])
      |-> ##[1:3] powerdown_or_irq_pin_o) else $error("test irq missing");
   test_stop_a: assert property (ctl_wr_s ##0 pwdata_i[2:1] == 2'b00
      |-> ##[1:3] !powerdown_or_irq_pin_o) else $error("irq not stopped");
endmodule
bind psic_top psic_monitor u_mon (.*);

/* tb/phy_status_interrupt_control_tb_top.sv */
`timescale 1ns/1ns
module phy_status_interrupt_control_tb_top
   import psic_pkg::*;
();
   logic        sys_clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0, pin_i = 0;
   logic [9:0]  paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [8:0]  in_v = '0;
   logic        pready, perr, pin_o, pin_oe, pd, irq, err;
   int          fails = 0, check_count = 0;
   localparam int          ev_pin [7] = '{8, 7, 4, 2, 1, 0, 6};
   localparam logic [9:0]  a_sum = {PSIC_IDX_SUMM, 2'b00}, a_ctl = {PSIC_IDX_CTRL, 2'b00};
   localparam logic [9:0]  a_ev = {PSIC_IDX_ISTAT, 2'b00}, a_sta = {PSIC_IDX_APBSTAT, 2'b00};
   always #50 sys_clk_i = ~sys_clk_i;
   psic_top dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(perr), .link_up_i(in_v[0]), .speed10_i(in_v[1]),
      .full_duplex_i(in_v[2]), .loopback_i(in_v[3]), .an_done_i(in_v[4]), .jabber_i(in_v[5]),
      .energy_i(in_v[6]), .fc_half_i(in_v[7]), .rx_half_i(in_v[8]),
      .powerdown_or_irq_pin_i(pin_i), .powerdown_or_irq_pin_o(pin_o),
      .powerdown_or_irq_pin_oe_o(pin_oe), .powerdown_o(pd), .irq_o(irq));
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      cyc(1);
      penable <= 1'b1;
      do begin
         cyc(1);
      end while (pready !== 1'b1);
      rd = prdata;
      err = perr;
      psel <= 1'b0;
      penable <= 1'b0;
      cyc(1);
   endtask
   task automatic rdc(input string nm, input logic [9:0] a, input logic [31:0] e, m);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd & m);
   endtask
   task automatic finish_test;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      fails++;
      finish_test;
   end
   initial begin
      cyc(2);
      reset_i <= 1'b0;
      cyc(3);
      rdc("ctrl_rst", a_ctl, 32'h0, 32'hFFFF_FFFF);
      for (int i = 0; i < 6; i++) begin
         in_v <= 9'h1 << i;
         cyc(6);
         rdc("summary", a_sum, 32'h1 << i, 32'h3F);
         rdc("sum_keep", a_sum, 32'h1 << i, 32'h3F);
      end
      in_v <= 9'h017;
      cyc(6);
      rdc("sum_valid", a_sum, 32'h17, 32'h3F);
      in_v <= '0;
      cyc(6);
      apb(1'b0, a_ev, 32'h0);
      apb(1'b1, a_ctl, 32'h1);
      apb(1'b1, a_ev, 32'h7F);
      for (int i = 0; i < 7; i++) begin
         in_v[ev_pin[i]] <= 1'b1;
         cyc(6);
         chk("gated", 32'h0, {31'h0, pin_o});
         rdc("pending", a_ev, (32'h1 << (i + 8)) | 32'h7F, 32'hFFFF);
         rdc("cleared", a_ev, 32'h7F, 32'hFFFF);
         in_v[ev_pin[i]] <= 1'b0;
         cyc(6);
         apb(1'b0, a_ev, 32'h0);
      end
      apb(1'b1, a_ctl, 32'h3);
      in_v[0] <= 1'b1;
      cyc(8);
      chk("event_irq", 32'h1, {31'h0, pin_o});
      rdc("sum_irq", a_sum, 32'h80, 32'h80);
      rdc("link_ev", a_ev, 32'h207F, 32'hFFFF);
      cyc(3);
      chk("irq_clr", 32'h0, {31'h0, pin_o});
      rdc("sum_clr", a_sum, 32'h0, 32'h80);
      apb(1'b1, a_ev, 32'h5F);
      in_v[0] <= 1'b0;
      cyc(8);
      chk("masked", 32'h0, {31'h0, pin_o});
      rdc("masked_ev", a_ev, 32'h205F, 32'hFFFF);
      apb(1'b1, a_ctl, 32'hFFFF_FFFD);
      rdc("ctrl_rsv", a_ctl, 32'h5, 32'hFFFF_FFFF);
      chk("test_irq", 32'h3, {30'h0, pin_oe, pin_o});
      apb(1'b1, a_ctl, 32'hFFF8);
      rdc("ctrl_off", a_ctl, 32'h0, 32'hFFFF_FFFF);
      chk("test_off", 32'h0, {30'h0, pin_oe, pin_o});
      pin_i <= 1'b1;
      cyc(4);
      chk("pd_in", 32'h1, {31'h0, pd});
      apb(1'b1, a_sta + 10'h4, 32'h0);
      apb(1'b1, a_sta, 32'h3);
      apb(1'b0, 10'h07C, 32'h0);
      chk("unmapped", 32'h1, {31'h0, err});
      cyc(3);
      chk("irq_unmasked", 32'h0, {31'h0, irq});
      apb(1'b1, a_sta + 10'h4, 32'h2);
      cyc(2);
      chk("irq_mask", 32'h1, {31'h0, irq});
      rdc("bus_err", a_sta, 32'h2, 32'h2);
      apb(1'b1, a_sta, 32'h3);
      cyc(3);
      chk("irq_w1c", 32'h0, {31'h0, irq});
      finish_test;
   end
endmodule
